//--- hdl/zxc_pkg.sv
// constants for the zero-cross detector control block
// assumes an APB master with 32-bit data on a 125 MHz pclk
//
// Function
// - fuse at 0: detection always on, software enable ignored
// - fuse 1, enable 1: detection on, pin in source/sink drive mode
// - fuse 1, enable 0: detection off, pin under remap/direction control
// - direction bit 5: 1 sinking, 0 sourcing; reversed when inverted
// - polarity bit 4 at 1 inverts the detector result
// - rise enable bit 1: low-to-high result edge sets the flag
// - fall enable bit 0: high-to-low result edge sets the flag
// - 8-bit control at index 0x91F; bits 6,3,2 unimplemented
// - any polarity change sets the flag, whatever the enable bit
// - software clears the flag; an edge in the clear cycle wins
// - request only with flag, mask, peripheral and global gates
// - detection and interrupts keep running in sleep
package zxc_pkg;

  localparam int unsigned ADDR_W = 16;

  // ****************************************************************
  // register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [ADDR_W-1:0] CTRL_IDX   = 16'h091F;
  localparam logic [ADDR_W-1:0] STATUS_IDX = 16'h0920;
  localparam logic [ADDR_W-1:0] MASK_IDX   = 16'h0921;
  localparam logic [ADDR_W-1:0] GATE_IDX   = 16'h0922;

  // ****************************************************************
  // control fields
  // ****************************************************************
  localparam int unsigned SOFT_EN_BIT  = 7;
  localparam int unsigned DIR_BIT      = 5;
  localparam int unsigned INVERT_BIT   = 4;
  localparam int unsigned RISE_EN_BIT  = 1;
  localparam int unsigned FALL_EN_BIT  = 0;
  localparam logic [7:0]  CTRL_WR_MASK = 8'h93;

  // status, mask and gate fields
  localparam int unsigned FLAG_BIT     = 0;
  localparam int unsigned PERIPH_BIT   = 0;
  localparam int unsigned GLOBAL_BIT   = 1;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic        SOFT_EN_RST  = 1'b0;
  localparam logic        INVERT_RST   = 1'b0;
  localparam logic        RISE_EN_RST  = 1'b0;
  localparam logic        FALL_EN_RST  = 1'b0;
  localparam logic        FLAG_RST     = 1'b0;
  localparam logic        MASK_RST     = 1'b0;
  localparam logic [1:0]  GATE_RST     = 2'h0;

  // ****************************************************************
  // timing counts in pclk cycles
  // ****************************************************************
  localparam int unsigned SYNC_STAGES  = 3;
  localparam int unsigned APB_WAIT     = 1;

endpackage

//--- hdl/zxc_sync.sv
// three-stage synchroniser with agreement filter
// assumes an input asynchronous to pclk
`timescale 1ns/100ps
`default_nettype none
module zxc_sync
  import zxc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      sync_out
);

  logic [SYNC_STAGES-1:0] stage_reg;
  logic [SYNC_STAGES-1:0] stage_next;
  logic                   out_reg;
  logic                   out_next;

  always_comb begin
    stage_next = {stage_reg[SYNC_STAGES-2:0], async_in};
    out_next   = out_reg;
    // first stage is read only by the second
    if (stage_reg[1] == stage_reg[2]) begin
      out_next = stage_reg[2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_reg <= '0;
      out_reg   <= 1'b0;
    end else begin
      stage_reg <= stage_next;
      out_reg   <= out_next;
    end
  end

  assign sync_out = out_reg;

endmodule
`default_nettype wire

//--- hdl/zxc_edge.sv
// rise and fall detector on a synchronous level
// assumes the level is already on pclk
`timescale 1ns/100ps
`default_nettype none
module zxc_edge
  import zxc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);

  logic prev_reg;
  logic prev_next;

  always_comb begin
    prev_next = level;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
    end
  end

  assign rise = level & ~prev_reg;
  assign fall = ~level & prev_reg;

endmodule
`default_nettype wire

//--- hdl/zxc_ctrl.sv
// zero-cross detector control: APB registers, enable, edges, interrupt
// assumes an APB master on pclk and an asynchronous comparator output
`timescale 1ns/100ps
`default_nettype none
module zxc_ctrl
  import zxc_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              detector_fuse,
  input  wire logic              comparator_raw,
  output logic                   pin_drive_en,
  output logic                   zero_cross_result,
  output logic                   irq
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [ADDR_W-1:0] byte_addr(
    input logic [ADDR_W-1:0] idx);
    byte_addr = {idx[ADDR_W-3:0], 2'b00};
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic        soft_enable_reg,     soft_enable_next;
  logic        invert_select_reg,   invert_select_next;
  logic        rise_irq_enable_reg, rise_irq_enable_next;
  logic        fall_irq_enable_reg, fall_irq_enable_next;
  logic        crossing_irq_flag_reg, crossing_irq_flag_next;
  logic        crossing_irq_mask_reg, crossing_irq_mask_next;
  logic [1:0]  gate_reg,            gate_next;
  logic        pready_reg,          pready_next;
  logic        pslverr_reg,         pslverr_next;
  logic [31:0] prdata_reg,          prdata_next;
  logic        pin_drive_reg,       pin_drive_next;
  logic        result_reg,          result_next;
  logic        irq_reg,             irq_next;

  logic        raw_sync;
  logic        result;
  logic        rise;
  logic        fall;
  logic        active;
  logic        fuse_sync;
  logic        access;
  logic        commit;
  logic        wr_ctrl;
  logic        wr_status;
  logic        wr_mask;
  logic        wr_gate;
  logic        mapped;
  logic        edge_event;
  logic        invert_change;
  logic        flag_set;

  // ****************************************************************
  // comparator and fuse path
  // ****************************************************************
  zxc_sync u_raw_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (comparator_raw),
    .sync_out (raw_sync)
  );

  // the fuse is a static level, but it still crosses in cleanly
  zxc_sync u_fuse_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (detector_fuse),
    .sync_out (fuse_sync)
  );

  // inversion after the synchroniser so each edge is seen once
  assign result = raw_sync ^ invert_select_reg;

  zxc_edge u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (result),
    .rise    (rise),
    .fall    (fall)
  );

  // fuse low overrides the software bit entirely
  assign active = ~fuse_sync | soft_enable_reg;

  // no sleep input: logic runs on pclk regardless of core state
  assign edge_event = active & ((rise & rise_irq_enable_reg)
                              | (fall & fall_irq_enable_reg));

  // ****************************************************************
  // APB decode
  // ****************************************************************
  assign access    = psel & penable;
  assign commit    = access & pready_reg;
  assign wr_ctrl   = commit & pwrite & pstrb[0]
                   & (paddr == byte_addr(CTRL_IDX));
  assign wr_status = commit & pwrite & pstrb[0]
                   & (paddr == byte_addr(STATUS_IDX));
  assign wr_mask   = commit & pwrite & pstrb[0]
                   & (paddr == byte_addr(MASK_IDX));
  assign wr_gate   = commit & pwrite & pstrb[0]
                   & (paddr == byte_addr(GATE_IDX));
  assign mapped    = (paddr == byte_addr(CTRL_IDX))
                   | (paddr == byte_addr(STATUS_IDX))
                   | (paddr == byte_addr(MASK_IDX))
                   | (paddr == byte_addr(GATE_IDX));

  assign invert_change = wr_ctrl
                       & (pwdata[INVERT_BIT] != invert_select_reg);
  assign flag_set = edge_event | invert_change;

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    soft_enable_next     = soft_enable_reg;
    invert_select_next   = invert_select_reg;
    rise_irq_enable_next = rise_irq_enable_reg;
    fall_irq_enable_next = fall_irq_enable_reg;
    crossing_irq_mask_next = crossing_irq_mask_reg;
    gate_next            = gate_reg;
    crossing_irq_flag_next = crossing_irq_flag_reg;
    // one wait state: ready rises on the second access cycle
    pready_next          = access & ~pready_reg;
    pslverr_next         = access & ~pready_reg & ~mapped;
    prdata_next          = prdata_reg;

    if (wr_ctrl) begin
      soft_enable_next     = pwdata[SOFT_EN_BIT];
      invert_select_next   = pwdata[INVERT_BIT];
      rise_irq_enable_next = pwdata[RISE_EN_BIT];
      fall_irq_enable_next = pwdata[FALL_EN_BIT];
    end
    if (wr_mask) begin
      crossing_irq_mask_next = pwdata[FLAG_BIT];
    end
    if (wr_gate) begin
      gate_next = pwdata[1:0];
    end

    // write one to clear; a set in the same cycle wins
    if (wr_status & pwdata[FLAG_BIT]) begin
      crossing_irq_flag_next = 1'b0;
    end
    if (flag_set) begin
      crossing_irq_flag_next = 1'b1;
    end

    if (access & ~pready_reg & ~pwrite) begin
      prdata_next = 32'h0000_0000;
      if (paddr == byte_addr(CTRL_IDX)) begin
        prdata_next[SOFT_EN_BIT] = soft_enable_reg;
        prdata_next[DIR_BIT]     = result;
        prdata_next[INVERT_BIT]  = invert_select_reg;
        prdata_next[RISE_EN_BIT] = rise_irq_enable_reg;
        prdata_next[FALL_EN_BIT] = fall_irq_enable_reg;
      end else if (paddr == byte_addr(STATUS_IDX)) begin
        prdata_next[FLAG_BIT] = crossing_irq_flag_reg;
      end else if (paddr == byte_addr(MASK_IDX)) begin
        prdata_next[FLAG_BIT] = crossing_irq_mask_reg;
      end else if (paddr == byte_addr(GATE_IDX)) begin
        prdata_next[1:0] = gate_reg;
      end
    end

    pin_drive_next = active;
    result_next    = result;
    irq_next       = crossing_irq_flag_next & crossing_irq_mask_next
                   & gate_next[PERIPH_BIT] & gate_next[GLOBAL_BIT];
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_enable_reg       <= SOFT_EN_RST;
      invert_select_reg     <= INVERT_RST;
      rise_irq_enable_reg   <= RISE_EN_RST;
      fall_irq_enable_reg   <= FALL_EN_RST;
      crossing_irq_flag_reg <= FLAG_RST;
      crossing_irq_mask_reg <= MASK_RST;
      gate_reg              <= GATE_RST;
      pready_reg            <= 1'b0;
      pslverr_reg           <= 1'b0;
      prdata_reg            <= 32'h0000_0000;
      pin_drive_reg         <= 1'b0;
      result_reg            <= 1'b0;
      irq_reg               <= 1'b0;
    end else begin
      soft_enable_reg       <= soft_enable_next;
      invert_select_reg     <= invert_select_next;
      rise_irq_enable_reg   <= rise_irq_enable_next;
      fall_irq_enable_reg   <= fall_irq_enable_next;
      crossing_irq_flag_reg <= crossing_irq_flag_next;
      crossing_irq_mask_reg <= crossing_irq_mask_next;
      gate_reg              <= gate_next;
      pready_reg            <= pready_next;
      pslverr_reg           <= pslverr_next;
      prdata_reg            <= prdata_next;
      pin_drive_reg         <= pin_drive_next;
      result_reg            <= result_next;
      irq_reg               <= irq_next;
    end
  end

  assign prdata            = prdata_reg;
  assign pready            = pready_reg;
  assign pslverr           = pslverr_reg;
  assign pin_drive_en      = pin_drive_reg;
  assign zero_cross_result = result_reg;
  assign irq               = irq_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_rise_seen;
    active && rise && rise_irq_enable_reg;
  endsequence

  sequence s_fall_seen;
    active && fall && fall_irq_enable_reg;
  endsequence

  // release edge excluded: its flops still load reset values there
  a_fuse_low_on: assert property (
    presetn && !fuse_sync |=> pin_drive_en)
    else $error("fuse low but pin drive off");

  a_soft_enable_drive: assert property (
    fuse_sync && soft_enable_reg |=> pin_drive_en)
    else $error("enabled but pin drive off");

  a_disabled_idle: assert property (
    fuse_sync && !soft_enable_reg |=> !pin_drive_en)
    else $error("disabled but pin drive on");

  a_dir_read_value: assert property (
    access && !pready_reg && !pwrite && paddr == byte_addr(CTRL_IDX)
    |=> prdata[DIR_BIT] == ($past(raw_sync) ^ $past(invert_select_reg)))
    else $error("direction bit read wrong");

  a_invert_result: assert property (
    ##1 zero_cross_result == ($past(raw_sync) ^ $past(invert_select_reg)))
    else $error("result polarity wrong");

  a_rise_sets_flag: assert property (
    s_rise_seen |=> crossing_irq_flag_reg)
    else $error("rise did not set flag");

  a_fall_sets_flag: assert property (
    s_fall_seen |=> crossing_irq_flag_reg)
    else $error("fall did not set flag");

  a_unimpl_zero: assert property (
    pready && !$past(pwrite) && $past(paddr) == byte_addr(CTRL_IDX)
    |-> prdata[6] == 1'b0 && prdata[3:2] == 2'b00
        && prdata[31:8] == 24'h000000)
    else $error("unimplemented control bits read nonzero");

  a_invert_change_irq: assert property (
    wr_ctrl && pwdata[INVERT_BIT] != invert_select_reg
    |=> crossing_irq_flag_reg)
    else $error("polarity change did not set flag");

  a_set_beats_clear: assert property (
    wr_status && pwdata[FLAG_BIT] && flag_set |=> crossing_irq_flag_reg)
    else $error("edge lost against clear");

  a_irq_gating: assert property (
    irq |-> crossing_irq_flag_reg && crossing_irq_mask_reg
            && gate_reg == 2'b11)
    else $error("interrupt without all gates");

  a_sync_latency: assert property (
    $rose(raw_sync) |-> $past(comparator_raw, 3))
    else $error("synchroniser output ahead of input");

  a_apb_wait: assert property (
    access && !pready_reg |=> pready ##1 !pready)
    else $error("apb wait state wrong");

endmodule
`default_nettype wire

//--- verif/zxc_comp_model.sv
// comparator and sensing pin seen from the control block
// assumes the bench calls drive() just after a rising pclk edge
`timescale 1ns/100ps
`default_nettype none
module zxc_comp_model (
  input  wire logic pclk,
  output var logic  comparator_raw
);
  initial comparator_raw = 1'b0;

  // ****************************************************************
  // level changes
  // ****************************************************************
  // a crossing is held well past the synchroniser depth so the
  // agreement filter always sees it; a glitchy pin is not modelled
  task automatic drive(input logic lvl);
    comparator_raw <= lvl;
    repeat (8) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

//--- verif/zxc_ctrl_tb.sv
// self-checking bench for the zero-cross control block
// assumes zxc_pkg, zxc_ctrl and zxc_comp_model are compiled first
`timescale 1ns/100ps
`default_nettype none
module zxc_ctrl_tb import zxc_pkg::*;;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic [3:0]        pstrb;
  logic              pready;
  logic              pslverr;
  logic              detector_fuse;
  logic              comparator_raw;
  logic              pin_drive_en;
  logic              zero_cross_result;
  logic              irq;
  logic [31:0]       rd;
  logic              err;
  int                mismatches;
  int                checks;

  localparam logic [ADDR_W-1:0] CTRL_A = CTRL_IDX << 2;
  localparam logic [ADDR_W-1:0] STAT_A = STATUS_IDX << 2;
  localparam logic [ADDR_W-1:0] MASK_A = MASK_IDX << 2;
  localparam logic [ADDR_W-1:0] GATE_A = GATE_IDX << 2;

  zxc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .detector_fuse(detector_fuse), .comparator_raw(comparator_raw),
    .pin_drive_en(pin_drive_en), .zero_cross_result(zero_cross_result),
    .irq(irq));

  zxc_comp_model cmp (.pclk(pclk), .comparator_raw(comparator_raw));

  always #4 pclk = ~pclk;

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic stop_test();
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // an idle edge after each transfer keeps psel from being
  // assigned twice in one time step between transfers
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic flag_is(input logic f, input logic q);
    repeat (3) @(posedge pclk);
    apb(1'b0, STAT_A, 32'h0);
    chk(rd, {31'h0, f});
    chk({31'h0, irq}, {31'h0, q});
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    apb(1'b0, CTRL_A, 32'h0);
    chk(rd, 32'h0);
    // lane 0 strobe low: the write must not land
    pstrb <= 4'hE;
    apb(1'b1, CTRL_A, 32'hFF);
    pstrb <= 4'hF;
    apb(1'b0, CTRL_A, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, MASK_A, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 16'h0000, 32'hFF);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 16'h0000, 32'h0);
    chk(rd, 32'h0);
  endtask

  // unimplemented bits read 0, direction follows the inverted result
  task automatic t_regs();
    apb(1'b1, CTRL_A, 32'hFF);
    apb(1'b0, CTRL_A, 32'h0);
    chk(rd, 32'hB3);
    chk({31'h0, zero_cross_result}, 32'h1);
    apb(1'b1, CTRL_A, 32'h0);
    apb(1'b1, STAT_A, 32'h1);
    flag_is(1'b0, 1'b0);
  endtask

  task automatic t_enable();
    repeat (8) @(posedge pclk);
    chk({31'h0, pin_drive_en}, 32'h0);
    apb(1'b1, CTRL_A, 32'h80);
    // drive enable registers one edge after the enable bit lands
    @(posedge pclk);
    chk({31'h0, pin_drive_en}, 32'h1);
    apb(1'b1, CTRL_A, 32'h0);
    detector_fuse <= 1'b0;
    repeat (8) @(posedge pclk);
    chk({31'h0, pin_drive_en}, 32'h1);
    detector_fuse <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask

  task automatic t_edges();
    apb(1'b1, MASK_A, 32'h1);
    apb(1'b1, GATE_A, 32'h3);
    apb(1'b1, CTRL_A, 32'h82);
    cmp.drive(1'b1);
    flag_is(1'b1, 1'b1);
    // comparator high, no inversion: direction reads sinking
    apb(1'b0, CTRL_A, 32'h0);
    chk(rd, 32'hA2);
    apb(1'b1, STAT_A, 32'h1);
    flag_is(1'b0, 1'b0);
    cmp.drive(1'b0);
    flag_is(1'b0, 1'b0);
    apb(1'b1, CTRL_A, 32'h81);
    cmp.drive(1'b1);
    flag_is(1'b0, 1'b0);
    cmp.drive(1'b0);
    flag_is(1'b1, 1'b1);
    for (int g = 0; g < 3; g++) begin
      apb(1'b1, GATE_A, 32'(g));
      flag_is(1'b1, 1'b0);
    end
    apb(1'b1, GATE_A, 32'h3);
    apb(1'b1, MASK_A, 32'h0);
    flag_is(1'b1, 1'b0);
    apb(1'b1, MASK_A, 32'h1);
    apb(1'b1, STAT_A, 32'h1);
    flag_is(1'b0, 1'b0);
  endtask

  // detection off: crossings ignored, a polarity flip still counts
  task automatic t_disabled();
    apb(1'b1, CTRL_A, 32'h03);
    cmp.drive(1'b1);
    cmp.drive(1'b0);
    flag_is(1'b0, 1'b0);
    apb(1'b1, CTRL_A, 32'h13);
    flag_is(1'b1, 1'b1);
    chk({31'h0, zero_cross_result}, 32'h1);
    apb(1'b1, CTRL_A, 32'h00);
    apb(1'b1, STAT_A, 32'h1);
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    detector_fuse = 1'b1;
    mismatches = 0;
    checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_regs();
    t_enable();
    t_edges();
    t_disabled();
    stop_test();
  end

  // whole run is about three hundred cycles; this bound only cuts a hang
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire
